// >>> common/tmr_pkg.sv
// Package: register map, field layout and types for the channel 1/2 mode control
package tmr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] timer_mode_control_ch1_addr = 16'hff74;
	localparam logic [15:0] timer_mode_control_ch2_addr = 16'hff78;
	localparam logic [7:0]  mode_control_reset          = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int count_run_bit    = 7;
	localparam int pwm_mode_bit     = 6;
	localparam int cascade_bit      = 4;
	localparam int force_set_bit    = 3;
	localparam int force_clear_bit  = 2;
	localparam int invert_level_bit = 1;
	localparam int output_gate_bit  = 0;
	localparam logic [7:0] mode_control_rd_mask = 8'hd3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       count_run;
		logic       pwm_mode;
		logic       cascade;
		logic       invert_level;
		logic       output_gate;
	} mode_ctrl_t;

	typedef struct packed {
		logic        write;
		logic        read;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cpu_req_t;

	typedef enum logic [1:0] {
		ch_idle    = 2'b00,
		ch_running = 2'b01,
		ch_pwm     = 2'b11
	} ch_state_t;

endpackage

// >>> core/tmr_channel.sv
// One 8-bit counter channel: counting, compare, output flip-flop
`timescale 1ns/1ps
`default_nettype none
module tmr_channel
	import tmr_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Control
	input  wire mode_ctrl_t ctrl,
	input  wire logic       force_set,
	input  wire logic       force_clear,
	input  wire logic       count_tick,
	input  wire logic       chain_hold,
	input  wire logic       chain_match,
	input  wire logic [7:0] compare_value,
	// Status and outputs
	output logic [7:0]      counter,
	output logic            match,
	output logic            carry_tick,
	output logic            compare_match_irq,
	output logic            timer_out
);

	logic       out_ff;
	logic       pwm_level;
	logic       full_match;
	ch_state_t  state;

	// Local compare; chain_match folds in the partner's half when cascaded
	assign match      = (counter == compare_value);
	assign full_match = match && chain_match;
	assign carry_tick = count_tick && (counter == 8'hff);

	// Mode state
	always_ff @(posedge clock) begin
		if (!rst_n)
			state <= ch_idle;
		else if (!ctrl.count_run)
			state <= ch_idle;
		else if (ctrl.pwm_mode)
			state <= ch_pwm;
		else
			state <= ch_running;
	end

	// Counter: cleared while stopped, restarts on match in clear mode
	always_ff @(posedge clock) begin
		if (!rst_n)
			counter <= 8'h00;
		else if (!ctrl.count_run || chain_hold)
			counter <= 8'h00; // [R1]
		else if (count_tick && !ctrl.pwm_mode && full_match)
			counter <= 8'h00; // [R2]
		else if (count_tick)
			counter <= counter + 8'h01; // [R2]
	end

	// Interrupt request pulse on compare match outside PWM mode
	always_ff @(posedge clock) begin
		if (!rst_n)
			compare_match_irq <= 1'b0;
		else
			compare_match_irq <= ctrl.count_run && !ctrl.pwm_mode
				&& count_tick && full_match; // [R13]
	end

	// Output flip-flop: force commands win over toggling
	always_ff @(posedge clock) begin
		if (!rst_n)
			out_ff <= 1'b0;
		else if (force_set && !force_clear)
			out_ff <= 1'b1; // [R5]
		else if (force_clear && !force_set)
			out_ff <= 1'b0; // [R5]
		else if (ctrl.count_run && !ctrl.pwm_mode && ctrl.invert_level
			&& count_tick && full_match)
			out_ff <= ~out_ff; // [R7] [R14]
	end

	// PWM: active while counter below compare, inactive when stopped
	always_comb begin
		if (state != ch_pwm || !ctrl.count_run)
			pwm_level = 1'b0; // [R10]
		else
			pwm_level = (counter < compare_value);
	end

	// Pin level; PWM level polarity chosen by the shared bit
	always_ff @(posedge clock) begin
		if (!rst_n)
			timer_out <= 1'b0;
		else if (!ctrl.output_gate)
			timer_out <= 1'b0; // [R9]
		else if (ctrl.pwm_mode)
			timer_out <= pwm_level ^ ctrl.invert_level; // [R8]
		else
			timer_out <= out_ff; // [R9]
	end

	stopped_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl.count_run |=> counter == 8'h00) // [R1]
		else $error("counter not cleared while stopped");
	force_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		force_set && !force_clear |=> out_ff) // [R5]
		else $error("force set did not set flip-flop");
	force_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		force_clear && !force_set |=> !out_ff) // [R5]
		else $error("force clear did not clear flip-flop");
	irq_no_pwm_a: assert property (@(posedge clock) disable iff (!rst_n)
		compare_match_irq |-> !$past(ctrl.pwm_mode)) // [R13]
		else $error("interrupt raised in PWM mode");
	invert_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl.invert_level && !force_set && !force_clear && !ctrl.pwm_mode
		|=> $stable(out_ff)) // [R7]
		else $error("flip-flop toggled with inversion off");

endmodule // tmr_channel
`default_nettype wire

// >>> core/tmr_mode_ctrl.sv
// Mode control registers and counters for timer channels 1 and 2
//
// Contract
// [R1] Count-run 0 stops, clears counter; 1 counts.
// [R2] Mode 0 clear on match; 1 PWM.
// [R3] Channel 1 bit 4 cascades with channel 0.
// [R4] Channel 2 bit 4 cascades with channel 1.
// [R5] Force field: 01 clears, 10 sets.
// [R6] Force bits always read back zero.
// [R7] Bit 1 outside PWM enables flip-flop inversion.
// [R8] Bit 1 in PWM selects active level.
// [R9] Bit 0 gates timer output onto pin.
// [R10] PWM stopped holds output inactive.
// [R11] Software masks before stopping, clears flag.
// [R12] Reset loads mode registers with zero.
// [R13] Match outside PWM raises interrupt request.
// [R14] Inversion toggles flip-flop on each match.
`timescale 1ns/1ps
`default_nettype none
module tmr_mode_ctrl
	import tmr_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// CPU memory bus
	input  wire cpu_req_t   cpu_req,
	output logic [7:0]      cpu_rdata,
	output logic            cpu_hit,
	// Count clocks from the clock-select logic, one-cycle pulses
	input  wire logic       tick_ch1,
	input  wire logic       tick_ch2,
	// Channel 0 links for cascade
	input  wire logic       carry_ch0,
	input  wire logic       match_ch0,
	input  wire logic       count_run_ch0,
	// Compare registers
	input  wire logic [7:0] compare_value_ch1,
	input  wire logic [7:0] compare_value_ch2,
	// Counter values
	output logic [7:0]      counter_ch1,
	output logic [7:0]      counter_ch2,
	// Interrupt requests, one-cycle pulses
	output logic            irq_ch1,
	output logic            irq_ch2,
	// Timer output pins and port-mode select
	output logic            timer_out_ch1,
	output logic            timer_out_ch2,
	output logic            output_gate_ch1,
	output logic            output_gate_ch2
);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	mode_ctrl_t ctrl [2];
	logic [1:0] force_set;
	logic [1:0] force_clear;
	logic [1:0] sel;
	logic [1:0] tick;
	logic [1:0] carry;
	logic [1:0] match;
	logic [1:0] hold;
	logic [1:0] chain_match;
	logic [1:0] irq_raw;
	logic [1:0] pin;
	logic [7:0] cnt [2];

	assign sel[0] = (cpu_req.addr == timer_mode_control_ch1_addr);
	assign sel[1] = (cpu_req.addr == timer_mode_control_ch2_addr);

	// Mode registers; force bits are one-shot and never stored
	generate
		for (genvar i = 0; i < 2; i++) begin : g_reg
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					ctrl[i] <= mode_ctrl_t'(5'h00); // [R12]
				end else if (cpu_req.write && sel[i]) begin
					ctrl[i].count_run    <= cpu_req.wdata[count_run_bit];
					ctrl[i].pwm_mode     <= cpu_req.wdata[pwm_mode_bit];
					ctrl[i].cascade      <= cpu_req.wdata[cascade_bit];
					ctrl[i].invert_level <= cpu_req.wdata[invert_level_bit];
					ctrl[i].output_gate  <= cpu_req.wdata[output_gate_bit];
				end
			end
			// Force pulses last exactly the write cycle
			assign force_set[i]   = cpu_req.write && sel[i]
				&& cpu_req.wdata[force_set_bit]; // [R5]
			assign force_clear[i] = cpu_req.write && sel[i]
				&& cpu_req.wdata[force_clear_bit]; // [R5]
		end
	endgenerate

	// Read data registered; force bits always read as zero
	always_ff @(posedge clock) begin
		if (!rst_n)
			cpu_rdata <= 8'h00;
		else if (cpu_req.read && sel[0])
			cpu_rdata <= {ctrl[0].count_run, ctrl[0].pwm_mode, 1'b0,
				ctrl[0].cascade, 2'b00, ctrl[0].invert_level,
				ctrl[0].output_gate}; // [R6]
		else if (cpu_req.read && sel[1])
			cpu_rdata <= {ctrl[1].count_run, ctrl[1].pwm_mode, 1'b0,
				ctrl[1].cascade, 2'b00, ctrl[1].invert_level,
				ctrl[1].output_gate}; // [R6]
		else
			cpu_rdata <= 8'h00;
	end

	assign cpu_hit = (cpu_req.read || cpu_req.write) && |sel;

	// ----------------------------------------------------------------
	// Cascade wiring
	// ----------------------------------------------------------------
	// Cascaded upper half counts on the lower half's carry; stopping the
	// lower half holds the upper half at zero.
	assign tick[0] = ctrl[0].cascade ? carry_ch0 : tick_ch1; // [R3]
	assign tick[1] = ctrl[1].cascade ? carry[0] : tick_ch2;  // [R4]
	assign hold[0] = ctrl[0].cascade && !count_run_ch0;      // [R3]
	assign hold[1] = ctrl[1].cascade && !ctrl[0].count_run;  // [R4]
	// Cascaded upper half matches only when the lower half also matches
	assign chain_match[0] = !ctrl[0].cascade || match_ch0; // [R3]
	assign chain_match[1] = !ctrl[1].cascade || match[0];  // [R4]

	generate
		for (genvar i = 0; i < 2; i++) begin : g_ch
			tmr_channel u_channel (
				.clock             (clock),
				.rst_n             (rst_n),
				.ctrl              (ctrl[i]),
				.force_set         (force_set[i]),
				.force_clear       (force_clear[i]),
				.count_tick        (tick[i]),
				.chain_hold        (hold[i]),
				.chain_match       (chain_match[i]),
				.compare_value     (i == 0 ? compare_value_ch1
					: compare_value_ch2),
				.counter           (cnt[i]),
				.match             (match[i]),
				.carry_tick        (carry[i]),
				.compare_match_irq (irq_raw[i]),
				.timer_out         (pin[i])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Lower half's request also fires in cascade; software masks it
	assign counter_ch1     = cnt[0];
	assign counter_ch2     = cnt[1];
	assign irq_ch1         = irq_raw[0]; // [R13]
	assign irq_ch2         = irq_raw[1]; // [R13]
	assign timer_out_ch1   = pin[0];
	assign timer_out_ch2   = pin[1];
	assign output_gate_ch1 = ctrl[0].output_gate; // [R9]
	assign output_gate_ch2 = ctrl[1].output_gate; // [R9]

	reset_zero_a: assert property (@(posedge clock)
		!rst_n |=> cpu_rdata == 8'h00 && !ctrl[0].count_run
		&& !ctrl[1].count_run) // [R12]
		else $error("mode registers not zero after reset");
	force_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		(cpu_rdata & ~mode_control_rd_mask) == 8'h00) // [R6]
		else $error("force bits read back nonzero");
	gate_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl[0].output_gate && !ctrl[1].output_gate
		|=> !timer_out_ch1 && !timer_out_ch2) // [R9]
		else $error("timer output driven while gated off");
	pwm_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
		ctrl[0].pwm_mode && !ctrl[0].count_run && ctrl[0].output_gate
		##1 $stable(ctrl[0]) |-> timer_out_ch1 == ctrl[0].invert_level)
		// [R10]
		else $error("PWM output active while stopped");
	cascade_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
		ctrl[1].cascade |-> tick[1] == carry[0]) // [R4]
		else $error("cascade tick not from channel 1 carry");

endmodule // tmr_mode_ctrl
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the channel 1/2 timer mode control
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tmr_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic       clock;
	logic       rst_n;
	cpu_req_t   cpu_req;
	logic [7:0] cpu_rdata, cnt1, cnt2, cmp1, cmp2, rdv;
	logic       cpu_hit, tick1, tick2, carry0, match0, run0;
	logic       irq1, irq2, out1, out2, gate1, gate2, hit, irq;
	int         mismatches, checks;

	tmr_mode_ctrl i_tmr_mode_ctrl (.clock(clock), .rst_n(rst_n),
		.cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit),
		.tick_ch1(tick1), .tick_ch2(tick2), .carry_ch0(carry0),
		.match_ch0(match0), .count_run_ch0(run0),
		.compare_value_ch1(cmp1), .compare_value_ch2(cmp2),
		.counter_ch1(cnt1), .counter_ch2(cnt2), .irq_ch1(irq1),
		.irq_ch2(irq2), .timer_out_ch1(out1), .timer_out_ch2(out2),
		.output_gate_ch1(gate1), .output_gate_ch2(gate2));

	// Free-running 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Shared tasks; all driving starts at a falling edge
	// ------------------------------------------------------------
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(logic [15:0] a, logic [7:0] d);
		cpu_req = '{1'b1, 1'b0, a, d};
		@(negedge clock);
		cpu_req = '0;
		@(negedge clock); // Let registered outputs settle
	endtask

	task automatic rd(logic [15:0] a);
		cpu_req = '{1'b0, 1'b1, a, 8'h00};
		#1 hit = cpu_hit;
		@(negedge clock);
		cpu_req = '0;
		rdv = cpu_rdata; // Data stands one cycle only
	endtask

	// One count pulse; irq is sampled in the single cycle it stands
	task automatic tick(int ch);
		if (ch == 0) tick1 = 1'b1;
		else tick2 = 1'b1;
		@(negedge clock);
		tick1 = 1'b0;
		tick2 = 1'b0;
		irq = (ch == 0) ? irq1 : irq2;
		@(negedge clock);
	endtask

	function automatic logic [15:0] adr(int ch);
		return (ch == 0) ? timer_mode_control_ch1_addr : timer_mode_control_ch2_addr;
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset(int ch);
		rd(adr(ch));
		check("reset value", rdv, mode_control_reset);
		check("hit", {7'h0, hit}, 8'h01);
		check("pin", {7'h0, (ch == 0) ? out1 : out2}, 8'h00);
	endtask

	task automatic t_count(int ch);
		wr(adr(ch), 8'h81);
		for (int i = 1; i <= 6; i++) begin
			tick(ch);
			check("count", (ch == 0) ? cnt1 : cnt2, 8'(i % 4));
			check("irq", {7'h0, irq}, {7'h0, i == 4});
		end
		check("gate", {7'h0, (ch == 0) ? gate1 : gate2}, 8'h01);
		// Stop with no match pending, so no stray request follows
		wr(adr(ch), 8'h01);
		check("stop clears", (ch == 0) ? cnt1 : cnt2, 8'h00);
	endtask

	task automatic t_force(int ch);
		// Force code 11 is prohibited for software, so it is never sent
		logic [7:0] seq [5] = '{8'h09, 8'h08, 8'h01, 8'h05, 8'h05};
		logic [7:0] exp [5] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
		foreach (seq[i]) begin
			wr(adr(ch), seq[i]);
			check("pin", {7'h0, (ch == 0) ? out1 : out2}, exp[i]);
		end
		rd(adr(ch));
		check("force readback", rdv, 8'h01);
	endtask

	task automatic t_invert;
		wr(timer_mode_control_ch1_addr, 8'h83);
		repeat (2) tick(0);
		@(negedge clock);
		check("toggle on", {7'h0, out1}, 8'h01);
		repeat (2) tick(0);
		@(negedge clock);
		check("toggle off", {7'h0, out1}, 8'h00);
		wr(timer_mode_control_ch1_addr, 8'h00);
	endtask

	task automatic t_pwm;
		wr(timer_mode_control_ch1_addr, 8'h41);
		check("pwm stop high", {7'h0, out1}, 8'h00);
		wr(timer_mode_control_ch1_addr, 8'h43);
		check("pwm stop low", {7'h0, out1}, 8'h01);
		wr(timer_mode_control_ch1_addr, 8'hc1);
		// Mode state lags the register by one edge, pin by one more
		@(negedge clock);
		check("pwm active", {7'h0, out1}, 8'h01);
		repeat (2) tick(0);
		@(negedge clock);
		check("pwm inactive", {7'h0, out1}, 8'h00);
		wr(timer_mode_control_ch1_addr, 8'h00);
	endtask

	// Channel 0 stopped and no carry from channel 1, so cascaded upper counters must hold at zero
	task automatic t_cascade;
		wr(timer_mode_control_ch1_addr, 8'h90);
		wr(timer_mode_control_ch2_addr, 8'h00);
		wr(timer_mode_control_ch2_addr, 8'h90);
		tick(0);
		tick(1);
		check("cascade ch1", cnt1, 8'h00);
		check("cascade ch2", cnt2, 8'h00);
		// Lower half running: its carry alone advances the upper half
		run0 = 1'b1;
		carry0 = 1'b1;
		@(negedge clock);
		carry0 = 1'b0;
		@(negedge clock);
		check("cascade carry", cnt1, 8'h01);
		run0 = 1'b0;
		rd(16'hff75);
		check("unmapped data", rdv, 8'h00);
		check("unmapped hit", {7'h0, hit}, 8'h00);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		{rst_n, tick1, tick2, carry0, match0, run0} = '0;
		cpu_req = '0;
		cmp1 = 8'h03;
		cmp2 = 8'h03;
		mismatches = 0;
		checks = 0;
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		for (int ch = 0; ch < 2; ch++) begin
			t_reset(ch);
			t_count(ch);
			t_force(ch);
		end
		cmp1 = 8'h01;
		t_invert();
		cmp1 = 8'h02;
		t_pwm();
		t_cascade();
		print_verdict();
	end

	// Whole run is about a hundred cycles; ten thousand is ample
	initial begin
		#50000;
		mismatches++;
		print_verdict();
	end
endmodule // tb
`default_nettype wire
